// File: test/can_bus_model.sv
// Purpose: behavioural CAN bus as seen by the transceiver receiver
// Assumes: bus is recessive (1) unless some node pulls it dominant
// Notes: stuck_rec models an open bus, other_dom another node transmitting
`timescale 1ns/100ps
module can_bus_model (
  // Driver side
  input wire logic bus_drive_dom,
  input wire logic other_dom,
  input wire logic stuck_rec,
  // Receiver side
  output logic bus_rx
);
  // Wired-and bus; a broken line ignores every driver
  assign bus_rx = stuck_rec ? 1'b1 : ~(bus_drive_dom | other_dom);
endmodule

// File: test/testbench.sv
// Purpose: self-checking bench for the transceiver control block
// Assumes: short timeouts set through parameters, 10 MHz clock
// Notes: pins are driven just after the rising edge by non-blocking assignment
`timescale 1ns/100ps
module testbench;
  logic clk, sys_rst, tx_input, tx_disable_pin, bus_rx, rx_output;
  logic bus_drive_dom, termination_on, bus_to_ground, digital_supply;
  logic thermal, watchdog, tx_enabled, wake_event, other_dom, stuck_rec;
  logic [3:0] cmd_v;
  can_xcvr_pkg::xcvr_cfg_t cfg;
  can_xcvr_pkg::fault_flags_t status;
  can_xcvr_pkg::xcvr_mode_t mode;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int k;

  can_transceiver_control #(.TX_DOM_TIMEOUT(50), .BUS_DOM_TIMEOUT(80), .WAKE_FRAME(200)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .tx_input(tx_input), .rx_output(rx_output),
    .tx_disable_pin(tx_disable_pin), .bus_rx(bus_rx), .bus_drive_dom(bus_drive_dom),
    .termination_on(termination_on), .bus_to_ground(bus_to_ground), .digital_supply(digital_supply),
    .main_buck_thermal_shutdown(thermal), .watchdog(watchdog), .cfg(cfg), .sleep_cmd(cmd_v[3]),
    .wake_cmd(cmd_v[2]), .standby_cmd(cmd_v[1]), .status_read(cmd_v[0]), .status(status),
    .mode(mode), .tx_enabled(tx_enabled), .wake_event(wake_event));
  can_bus_model bus_u (.bus_drive_dom(bus_drive_dom), .other_dom(other_dom), .stuck_rec(stuck_rec),
    .bus_rx(bus_rx));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Order of bits: sleep, wake, standby, status read
  task automatic send(input logic [3:0] v);
    cmd_v <= v;
    tick(1);
    cmd_v <= 4'h0;
    tick(3);
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int i;
    for (i = 0; i < lim && mode !== m; i++) @(posedge clk);
    check(mode, m);
  endtask
  task automatic tx_pulse();
    tx_input <= 1'b0;
    tick(5);
    tx_input <= 1'b1;
    tick(25);
  endtask
  task automatic bus_pulse(input int n);
    other_dom <= 1'b1;
    tick(n);
    other_dom <= 1'b0;
    tick(n);
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    tx_input = 1'b1;
    tx_disable_pin = 1'b0;
    digital_supply = 1'b1;
    thermal = 1'b0;
    watchdog = 1'b0;
    cfg = '0;
    cmd_v = 4'h0;
    other_dom = 1'b0;
    stuck_rec = 1'b0;
    tick(12);
    check(mode, 8'h2);
    sys_rst <= 1'b0;
    wait_mode(2'h0, 10);
    tick(2);
    check(tx_enabled, 8'h1);
    $display("test power_on done");
    tx_input <= 1'b0;
    tick(60);
    check(status.tx_dom_timeout, 8'h1);
    check(tx_enabled, 8'h0);
    other_dom <= 1'b1;
    tx_input <= 1'b1;
    tick(5);
    check(rx_output, 8'h0);
    check(tx_enabled, 8'h0);
    other_dom <= 1'b0;
    send(4'h1);
    check(status, 8'h0);
    check(tx_enabled, 8'h1);
    $display("test tx_timeout done");
    cfg.err_handling_off <= 1'b1;
    tx_input <= 1'b0;
    tick(60);
    check(status, 8'h0);
    check(tx_enabled, 8'h1);
    send(4'h1);
    check(status, 8'h0);
    tx_input <= 1'b1;
    cfg <= '0;
    tick(5);
    $display("test err_off done");
    stuck_rec <= 1'b1;
    repeat (3) tx_pulse();
    check(status, 8'h0);
    // One followed edge must restart both miss counts
    stuck_rec <= 1'b0;
    tx_pulse();
    stuck_rec <= 1'b1;
    repeat (3) tx_pulse();
    check(status, 8'h0);
    tx_pulse();
    tick(2);
    check(status, 8'h5);
    check(tx_enabled, 8'h0);
    stuck_rec <= 1'b0;
    send(4'h1);
    check(tx_enabled, 8'h1);
    $display("test perm_recessive done");
    other_dom <= 1'b1;
    tick(100);
    check(status, 8'h2);
    check(tx_enabled, 8'h1);
    other_dom <= 1'b0;
    send(4'h1);
    $display("test perm_dominant done");
    for (k = 0; k < 2; k++) begin
      if (k == 0) thermal <= 1'b1;
      else watchdog <= 1'b1;
      tick(4);
      check(tx_enabled, 8'h0);
      thermal <= 1'b0;
      watchdog <= 1'b0;
      tick(4);
      check(tx_enabled, 8'h1);
    end
    $display("test supervision done");
    for (k = 0; k < 2; k++) begin
      if (k == 0) cfg.receive_only <= 1'b1;
      else tx_disable_pin <= 1'b1;
      tx_input <= 1'b0;
      tick(6);
      check(bus_drive_dom, 8'h0);
      check(termination_on, 8'h1);
      cfg.loopback <= 1'b1;
      stuck_rec <= 1'b1;
      tick(6);
      check(rx_output, 8'h0);
      tx_input <= 1'b1;
      cfg <= '0;
      tx_disable_pin <= 1'b0;
      stuck_rec <= 1'b0;
      tick(20);
      send(4'h1);
    end
    $display("test receive_only done");
    send(4'h8);
    check(mode, 8'h2);
    check(bus_to_ground, 8'h1);
    check(termination_on, 8'h0);
    send(4'h4);
    wait_mode(2'h0, 10);
    check(termination_on, 8'h1);
    $display("test sleep done");
    cfg <= 5'h02;
    send(4'h2);
    check(mode, 8'h1);
    other_dom <= 1'b1;
    wait_mode(2'h0, 100);
    check(wake_event, 8'h1);
    other_dom <= 1'b0;
    cfg <= 5'h00;
    tick(5);
    send(4'h2);
    bus_pulse(60);
    check(mode, 8'h1);
    send(4'h4);
    wait_mode(2'h0, 10);
    cfg <= 5'h03;
    tick(5);
    send(4'h2);
    bus_pulse(10);
    bus_pulse(10);
    tick(250);
    check(mode, 8'h1);
    // A second pulse outside the frame must not complete the pattern
    bus_pulse(30);
    tick(200);
    bus_pulse(30);
    check(mode, 8'h1);
    bus_pulse(30);
    wait_mode(2'h0, 60);
    // Standby entered while the bus is held dominant wakes on the recessive level
    other_dom <= 1'b1;
    tick(90);
    send(4'h2);
    check(mode, 8'h1);
    other_dom <= 1'b0;
    wait_mode(2'h0, 60);
    check(wake_event, 8'h1);
    send(4'h1);
    $display("test wakeup done");
    report_and_stop();
  end
endmodule

// File: verilog/can_transceiver_control.sv
// Purpose: digital control and supervision of a CAN physical-layer transceiver
// Assumes: single 10 MHz clock, bus and pins sampled through two flip-flops
// Notes: tx_input/bus/rx_output are 0 when dominant; analog side not modelled
`timescale 1ns/100ps
`include "can_xcvr_consts.svh"

// Summary of operation
// [RL1] Transceiver enabled as soon as the digital supply power-on reset releases.
// [RL2] Of the faults, only tx timeout, bus/rx recessive, thermal, watchdog disable transmitter.
// [RL3] Receiver stays on under every fault condition.
// [RL4] A control bit turns off all error handling.
// [RL5] Tx dominant beyond timeout disables transmitter until status read clears.
// [RL6] Bus not following tx dominant 4 times disables transmitter until read.
// [RL7] Bus dominant beyond timeout latches status; transmitter stays enabled.
// [RL8] Rx output not following tx 4 times disables transmitter until read.
// [RL9] Bus wakeup monitored only in standby with wake option enabled.
// [RL10] Pattern wake: two dominant pulses over 2 us, gap over 2 us, within 1 ms.
// [RL11] Standby entered after permanent dominant wakes on recessive level.
// [RL12] Without pattern wake, any filtered bus transition wakes the device.
// [RL13] Sleep command deactivates, termination off, bus lines pulled to ground (code accepts it in active mode only).
// [RL14] Receive-only bit disables transmitter; listening and termination remain.
// [RL15] Disable pin high gives the same receive-only behaviour.
// [RL16] Loopback routes tx input straight to the receive output.
// [RL17] Disable pin active high: monitor only, termination stays active.
// [RL18] Follow counters count consecutive misses, restart on a followed edge.
module can_transceiver_control #(
  parameter int TX_DOM_TIMEOUT = `TX_DOM_TIMEOUT_CYC,
  parameter int BUS_DOM_TIMEOUT = `BUS_DOM_TIMEOUT_CYC,
  parameter int WAKE_FRAME = `WAKE_FRAME_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Protocol handler side
  input wire logic tx_input,
  output logic rx_output,
  input wire logic tx_disable_pin,
  // Bus side (receiver comparator in, driver out)
  input wire logic bus_rx,
  output logic bus_drive_dom,
  output logic termination_on,
  output logic bus_to_ground,
  // Supervision inputs
  input wire logic digital_supply,
  input wire logic main_buck_thermal_shutdown,
  input wire logic watchdog,
  // Control
  input wire can_xcvr_pkg::xcvr_cfg_t cfg,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  input wire logic standby_cmd,
  input wire logic status_read,
  // Status
  output can_xcvr_pkg::fault_flags_t status,
  output can_xcvr_pkg::xcvr_mode_t mode,
  output logic tx_enabled,
  output logic wake_event
);
  logic [1:0] tx_s, bus_s, dis_s, sup_s;
  logic tx_in, bus_in, dis_in, sup_in;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_s <= 2'h3;
      bus_s <= 2'h3;
      dis_s <= 2'h0;
      sup_s <= 2'h0;
    end else begin
      tx_s <= {tx_s[0], tx_input};
      bus_s <= {bus_s[0], bus_rx};
      dis_s <= {dis_s[0], tx_disable_pin};
      sup_s <= {sup_s[0], digital_supply};
    end
  end
  assign tx_in = tx_s[1];
  assign bus_in = bus_s[1];
  assign dis_in = dis_s[1];
  assign sup_in = sup_s[1];

  logic tx_prev_reg, bus_prev_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_prev_reg <= 1'b1;
      bus_prev_reg <= 1'b1;
    end else begin
      tx_prev_reg <= tx_in;
      bus_prev_reg <= bus_in;
    end
  end
  wire tx_fall = tx_prev_reg & ~tx_in;

  // Dominant duration timers
  logic [31:0] tx_dom_cnt_reg, bus_dom_cnt_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_dom_cnt_reg <= 32'h0;
      bus_dom_cnt_reg <= 32'h0;
    end else begin
      tx_dom_cnt_reg <= tx_in ? 32'h0 : (tx_dom_cnt_reg > TX_DOM_TIMEOUT ? tx_dom_cnt_reg : tx_dom_cnt_reg + 32'h1);
      bus_dom_cnt_reg <= bus_in ? 32'h0 :
        (bus_dom_cnt_reg > BUS_DOM_TIMEOUT ? bus_dom_cnt_reg : bus_dom_cnt_reg + 32'h1);
    end
  end
  wire tx_dom_to = tx_dom_cnt_reg == TX_DOM_TIMEOUT; // see [RL5]
  wire bus_dom_to = bus_dom_cnt_reg == BUS_DOM_TIMEOUT; // see [RL7]

  // Follow check: after each dominant tx edge while the transmitter is enabled, a window in which bus and rx must go dominant
  logic [4:0] win_reg;
  logic bus_seen_reg, rx_seen_reg;
  logic [2:0] bus_miss_reg, rx_miss_reg;
  wire win_end = win_reg == 5'h1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_reg <= 5'h0;
      bus_seen_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
    end else if (tx_fall & tx_enabled) begin
      win_reg <= 5'(`FOLLOW_WINDOW_CYC);
      bus_seen_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
    end else if (win_reg != 5'h0) begin
      win_reg <= win_reg - 5'h1;
      bus_seen_reg <= bus_seen_reg | ~bus_in;
      rx_seen_reg <= rx_seen_reg | ~rx_output;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_miss_reg <= 3'h0;
      rx_miss_reg <= 3'h0;
    end else if (win_end) begin
      // Restart after a flagged run too, so a fault that persists past a read is caught again
      bus_miss_reg <= (bus_seen_reg | bus_miss_reg == `FOLLOW_FAIL_LIMIT - 3'h1) ? 3'h0 : bus_miss_reg + 3'h1; // see [RL18]
      rx_miss_reg <= (rx_seen_reg | rx_miss_reg == `FOLLOW_FAIL_LIMIT - 3'h1) ? 3'h0 : rx_miss_reg + 3'h1; // see [RL18]
    end
  end
  wire bus_rec_evt = win_end & ~bus_seen_reg & (bus_miss_reg == `FOLLOW_FAIL_LIMIT - 3'h1); // see [RL6]
  wire rx_rec_evt = win_end & ~rx_seen_reg & (rx_miss_reg == `FOLLOW_FAIL_LIMIT - 3'h1); // see [RL8]

  // Sticky status; a new event beats the read clear
  wire chk = ~cfg.err_handling_off; // see [RL4]
  can_xcvr_pkg::fault_flags_t status_next;
  always_comb begin
    status_next = status_read ? '0 : status;
    if (chk & tx_dom_to) status_next.tx_dom_timeout = 1'b1; // see [RL5]
    if (chk & bus_rec_evt) status_next.bus_perm_recessive = 1'b1; // see [RL6]
    if (chk & bus_dom_to) status_next.bus_perm_dominant = 1'b1; // see [RL7]
    if (chk & rx_rec_evt) status_next.rx_perm_recessive = 1'b1; // see [RL8]
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status <= status_next;
    end
  end

  // Mode control
  logic perm_dom_standby_reg;
  logic [7:0] filt_cnt_reg;
  logic wake_go;
  logic boot_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= can_xcvr_pkg::MODE_SLEEP;
      perm_dom_standby_reg <= 1'b0;
    end else if (~sup_in) begin
      mode <= can_xcvr_pkg::MODE_SLEEP;
      perm_dom_standby_reg <= 1'b0;
    end else begin
      unique case (mode)
        can_xcvr_pkg::MODE_ACTIVE: begin
          if (sleep_cmd) begin
            mode <= can_xcvr_pkg::MODE_SLEEP; // see [RL13]
          end else if (standby_cmd) begin
            mode <= can_xcvr_pkg::MODE_STANDBY;
            perm_dom_standby_reg <= bus_dom_cnt_reg >= BUS_DOM_TIMEOUT; // see [RL11]
          end
        end
        can_xcvr_pkg::MODE_STANDBY: begin
          if (wake_go | wake_cmd) mode <= can_xcvr_pkg::MODE_ACTIVE;
        end
        can_xcvr_pkg::MODE_SLEEP: begin
          if (wake_cmd | boot_reg) begin
            mode <= can_xcvr_pkg::MODE_ACTIVE; // see [RL1]
          end
        end
        default: mode <= can_xcvr_pkg::MODE_SLEEP;
      endcase
    end
  end
  // Every supply release, at power-on or after a supply loss, brings the transceiver up by itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_reg <= 1'b1;
    end else if (sup_in & mode == can_xcvr_pkg::MODE_SLEEP & boot_reg) begin
      boot_reg <= 1'b0; // see [RL1]
    end else if (~sup_in) begin
      boot_reg <= 1'b1;
    end
  end

  // Wakeup detection
  wire monitor = (mode == can_xcvr_pkg::MODE_STANDBY) & cfg.wake_enable; // see [RL9]
  can_xcvr_pkg::pat_state_t pw_reg;
  logic [7:0] seg_cnt_reg;
  logic [31:0] frame_cnt_reg;
  wire seg_ok = seg_cnt_reg >= 8'(`WAKE_PULSE_MIN_CYC);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_cnt_reg <= 8'h0;
    end else begin
      filt_cnt_reg <= (~monitor | bus_in == bus_prev_reg & filt_cnt_reg == 8'h0) ? 8'h0 :
        (bus_in != bus_prev_reg ? 8'h1 : filt_cnt_reg + 8'h1);
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pw_reg <= can_xcvr_pkg::PW_IDLE;
      seg_cnt_reg <= 8'h0;
      frame_cnt_reg <= 32'h0;
    end else if (~monitor) begin
      pw_reg <= can_xcvr_pkg::PW_IDLE;
      seg_cnt_reg <= 8'h0;
      frame_cnt_reg <= 32'h0;
    end else begin
      seg_cnt_reg <= (bus_in != bus_prev_reg) ? 8'h0 : (seg_ok ? seg_cnt_reg : seg_cnt_reg + 8'h1);
      frame_cnt_reg <= (pw_reg == can_xcvr_pkg::PW_IDLE) ? 32'h0 : frame_cnt_reg + 32'h1;
      if (pw_reg != can_xcvr_pkg::PW_IDLE && frame_cnt_reg >= WAKE_FRAME) begin
        pw_reg <= can_xcvr_pkg::PW_IDLE; // see [RL10]
      end else begin
        unique case (pw_reg)
          can_xcvr_pkg::PW_IDLE: if (bus_prev_reg & ~bus_in) pw_reg <= can_xcvr_pkg::PW_DOM1;
          can_xcvr_pkg::PW_DOM1: if (bus_in) pw_reg <= seg_ok ? can_xcvr_pkg::PW_GAP : can_xcvr_pkg::PW_IDLE;
          can_xcvr_pkg::PW_GAP: if (~bus_in) pw_reg <= seg_ok ? can_xcvr_pkg::PW_DOM2 : can_xcvr_pkg::PW_IDLE;
          can_xcvr_pkg::PW_DOM2: if (seg_ok) pw_reg <= can_xcvr_pkg::PW_DONE;
            else if (bus_in) pw_reg <= can_xcvr_pkg::PW_IDLE;
          can_xcvr_pkg::PW_DONE: pw_reg <= can_xcvr_pkg::PW_DONE;
          default: pw_reg <= can_xcvr_pkg::PW_IDLE;
        endcase
      end
    end
  end
  always_comb begin
    if (~monitor) begin
      wake_go = 1'b0;
    end else if (perm_dom_standby_reg & bus_in & seg_ok) begin
      wake_go = 1'b1; // see [RL11]
    end else if (cfg.pattern_wake) begin
      wake_go = pw_reg == can_xcvr_pkg::PW_DONE; // see [RL10]
    end else begin
      wake_go = filt_cnt_reg >= 8'(`WAKE_FILTER_CYC); // see [RL12]
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake_go;
    end
  end

  // Transmitter enable and pin outputs
  wire tx_fault = status.tx_dom_timeout | status.bus_perm_recessive | status.rx_perm_recessive; // see [RL2]
  wire tx_en_next = (mode == can_xcvr_pkg::MODE_ACTIVE) & ~tx_fault & ~main_buck_thermal_shutdown & ~watchdog
    & ~cfg.receive_only & ~dis_in; // see [RL14] see [RL15] see [RL17]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_enabled <= 1'b0;
      bus_drive_dom <= 1'b0;
      rx_output <= 1'b1;
      termination_on <= 1'b0;
      bus_to_ground <= 1'b1;
    end else begin
      tx_enabled <= tx_en_next;
      bus_drive_dom <= tx_en_next & ~tx_in;
      rx_output <= cfg.loopback ? tx_in : bus_in; // see [RL16] see [RL3]
      termination_on <= mode != can_xcvr_pkg::MODE_SLEEP; // see [RL13] see [RL17]
      bus_to_ground <= mode == can_xcvr_pkg::MODE_SLEEP; // see [RL13]
    end
  end

  a_bus_dom_keeps_tx: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(status.bus_perm_dominant) & ~status.tx_dom_timeout & ~status.bus_perm_recessive
    & ~status.rx_perm_recessive & mode == can_xcvr_pkg::MODE_ACTIVE & ~cfg.receive_only & ~dis_in
    & ~main_buck_thermal_shutdown & ~watchdog |-> ##1 tx_enabled) // see [RL7]
    else $error("bus dominant status disabled transmitter");
  a_fault_blocks_tx: assert property (@(posedge clk) disable iff (sys_rst)
    (status.tx_dom_timeout | status.bus_perm_recessive | status.rx_perm_recessive) |-> ##1 ~tx_enabled) // see [RL5]
    else $error("transmitter enabled with latched fault");
  a_loop_routes_tx: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.loopback |=> rx_output == $past(tx_in)) // see [RL16]
    else $error("loopback not routing tx input");
  a_rx_follows_bus: assert property (@(posedge clk) disable iff (sys_rst)
    ~cfg.loopback |=> rx_output == $past(bus_in)) // see [RL3]
    else $error("receiver path not following bus");
  a_rxonly_no_tx: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg.receive_only | dis_in) |=> ~bus_drive_dom & termination_on == ($past(mode) != can_xcvr_pkg::MODE_SLEEP)) // see [RL14]
    else $error("receive-only still driving");
  a_sleep_grounds: assert property (@(posedge clk) disable iff (sys_rst)
    mode == can_xcvr_pkg::MODE_SLEEP |=> bus_to_ground & ~termination_on & ~tx_enabled) // see [RL13]
    else $error("sleep mode not grounding bus");
  a_no_wake_off: assert property (@(posedge clk) disable iff (sys_rst)
    ~monitor |-> ##1 ~wake_event) // see [RL9]
    else $error("wake outside monitored standby");
  a_errs_off_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.err_handling_off & status_read |=> status == '0) // see [RL4]
    else $error("status set with error handling off");
endmodule

// File: verilog/can_xcvr_consts.svh
// Purpose: timing counts and limits for the transceiver control block
// Assumes: 10 MHz clock (100 ns period)
// Notes: times in ns, wake counts derived from the clock period, timeout and window counts given in cycles
`ifndef CAN_XCVR_CONSTS_SVH
`define CAN_XCVR_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define FOLLOW_FAIL_LIMIT 3'h4
`define WAKE_PULSE_MIN_NS 2000
`define WAKE_PULSE_MIN_CYC ((`WAKE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_FRAME_NS 1000000
`define WAKE_FRAME_CYC (`WAKE_FRAME_NS / `CLK_PERIOD_NS)
`define WAKE_FILTER_NS 4000
`define WAKE_FILTER_CYC ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TX_DOM_TIMEOUT_CYC 20000
`define BUS_DOM_TIMEOUT_CYC 20000
`define FOLLOW_WINDOW_CYC 16
`endif

// File: verilog/can_xcvr_pkg.sv
// Purpose: types shared by the transceiver control block
// Assumes: nothing
// Notes: constants live in can_xcvr_consts.svh
package can_xcvr_pkg;
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_SLEEP = 2'b10
  } xcvr_mode_t;
  typedef enum logic [2:0] {
    PW_IDLE = 3'b000,
    PW_DOM1 = 3'b001,
    PW_GAP = 3'b010,
    PW_DOM2 = 3'b011,
    PW_DONE = 3'b100
  } pat_state_t;
  typedef struct packed {
    logic tx_dom_timeout;
    logic bus_perm_recessive;
    logic bus_perm_dominant;
    logic rx_perm_recessive;
  } fault_flags_t;
  typedef struct packed {
    logic err_handling_off;
    logic receive_only;
    logic loopback;
    logic wake_enable;
    logic pattern_wake;
  } xcvr_cfg_t;
endpackage
